// File: src/tsic_edge.sv
`timescale 1ns/1ns
module tsic_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  input wire logic [1:0] sel,
  output logic hit
);
  import tsic_pkg::*;
  logic prev_ff;
  logic rise;
  logic fall;

  // follows the pin through reset too, so no false edge appears after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= pin;
    end else begin
      prev_ff <= pin;
    end
  end

  assign rise = pin & ~prev_ff;
  assign fall = ~pin & prev_ff;

  always_comb begin
    unique case (sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      EDGE_RSVD: hit = 1'b0;
    endcase
  end
endmodule // tsic_edge

// File: src/tsic_pkg.sv
package tsic_pkg;
  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_EDGE = 8'hbf;
  localparam logic [7:0] IDX_REQ = 8'hc8;
  localparam logic [7:0] IDX_EN = 8'hc9;
  localparam logic [7:0] IDX_STACK_POINTER_REG = 8'hdf;
  localparam logic [7:0] IDX_STAT = 8'hf0;
  localparam logic [7:0] IDX_MASK = 8'hf1;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int BIT_EXT = 0;
  localparam int BIT_TA = 4;
  localparam int BIT_TB = 5;
  localparam int BIT_GIE = 7;
  localparam int EDGE_LO = 3;
  localparam int EDGE_HI = 4;
  localparam logic [7:0] SRC_MASK = 8'h31;
  localparam logic [7:0] EDGE_MASK = 8'h18;
  localparam logic [7:0] EDGE_RST = 8'h10;
  localparam logic [7:0] STACK_POINTER_REG_LVL_MASK = 8'h03;
  localparam logic [7:0] STACK_POINTER_REG_RST = 8'h03;
  localparam logic [7:0] PROGRAM_FLAG_REG_KEEP = 8'hc0;
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h008;
  // ------------------------------------------------------------
  // edge-select codes and bus answers
  // ------------------------------------------------------------
  localparam logic [1:0] EDGE_RSVD = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: src/tsic_shadow.sv
`timescale 1ns/1ns
module tsic_shadow (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push_save,
  input wire logic pop_restore,
  input wire logic [7:0] accumulator_reg,
  input wire logic [7:0] program_flag_reg,
  output logic [7:0] acc_restore_ff,
  output logic [7:0] program_flag_reg_restore_ff,
  output logic restore_load_ff
);
  import tsic_pkg::*;
  logic [7:0] acc_buf_ff;
  logic [7:0] program_flag_reg_buf_ff;

  // one level only: a second save overwrites the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_buf_ff <= 8'h00;
      program_flag_reg_buf_ff <= 8'h00;
    end else if (push_save) begin
      acc_buf_ff <= accumulator_reg;
      program_flag_reg_buf_ff <= program_flag_reg & ~PROGRAM_FLAG_REG_KEEP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_restore_ff <= 8'h00;
      program_flag_reg_restore_ff <= 8'h00;
      restore_load_ff <= 1'b0;
    end else begin
      restore_load_ff <= pop_restore;
      if (pop_restore) begin
        acc_restore_ff <= acc_buf_ff;
        program_flag_reg_restore_ff <= program_flag_reg_buf_ff | (program_flag_reg & PROGRAM_FLAG_REG_KEEP);
      end
    end
  end
endmodule // tsic_shadow

// File: src/tsic_top.sv
// Operation
// - taken interrupt loads program counter with 8
// - one-level shadow saves, restores accumulator, flags
// - timeout and power-down flags never saved/restored
// - qualifying pin edge sets external request flag
// - external vectors only when enabled and requested or wake-latched
// - matching wake edge latched, serviced first
// - edge select bits 4:3 rise, fall, both
// - timer A overflow sets its request flag
// - timer A disabled never vectors
// - timer B overflow sets its request flag
// - timer B disabled never vectors
// - global enable bit 7 gates all vectoring (not irq), reset 0
// - entry clears global enable, pushes; return sets
// - enables at 0c9: bits 0, 4, 5
// - requests at 0c8, same bits, writable
`timescale 1ns/1ns
module tsic_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tsic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tsic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_pin_interrupt,
  input wire logic timer_a_overflow,
  input wire logic timer_b_overflow,
  input wire logic power_down_mode,
  input wire logic core_accept,
  input wire logic return_from_interrupt,
  input wire logic push_save,
  input wire logic pop_restore,
  input wire logic [7:0] accumulator_reg,
  input wire logic [7:0] program_flag_reg,
  output logic vector_load,
  output logic [tsic_pkg::PC_W-1:0] vector_pc,
  output logic stack_push,
  output logic wake_up,
  output logic [7:0] acc_restore,
  output logic [7:0] program_flag_reg_restore,
  output logic restore_load,
  output logic irq
);
  import tsic_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_ff;
  logic aw_full_ff;
  logic [7:0] w_data_ff;
  logic w_lane_ff;
  logic w_full_ff;
  logic do_write;
  logic do_read;
  logic [7:0] wr_idx;
  logic wr_mapped;
  logic wr_en;
  logic wr_req;
  logic wr_edge;
  logic wr_stack_pointer_reg;
  logic wr_stat;
  logic wr_mask;
  logic [7:0] rd_idx;
  logic rd_mapped;
  logic [7:0] rd_val;
  logic [7:0] edge_sel_ff;
  logic [7:0] int_en_ff;
  logic [7:0] int_req_ff;
  logic [7:0] stack_pointer_reg_ff;
  logic [7:0] stat_ff;
  logic [7:0] mask_ff;
  logic wake_latch_ff;
  logic ext_hit;
  logic [7:0] hw_set;
  logic [7:0] nxt_req;
  logic [7:0] nxt_stat;
  logic pending;
  logic take;

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  tsic_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(external_pin_interrupt),
    .sel(edge_sel_ff[EDGE_HI:EDGE_LO]),
    .hit(ext_hit)
  );

  always_comb begin
    hw_set = 8'h00;
    hw_set[BIT_EXT] = ext_hit;
    hw_set[BIT_TA] = timer_a_overflow;
    hw_set[BIT_TB] = timer_b_overflow;
  end

  // ------------------------------------------------------------
  // shadow buffer
  // ------------------------------------------------------------
  tsic_shadow u_shadow (
    .aclk(aclk),
    .aresetn(aresetn),
    .push_save(push_save),
    .pop_restore(pop_restore),
    .accumulator_reg(accumulator_reg),
    .program_flag_reg(program_flag_reg),
    .acc_restore_ff(acc_restore),
    .program_flag_reg_restore_ff(program_flag_reg_restore),
    .restore_load_ff(restore_load)
  );

  // ------------------------------------------------------------
  // bus write channels
  // ------------------------------------------------------------
  assign do_write = aw_full_ff & w_full_ff & ~s_axi_bvalid;
  assign wr_idx = aw_addr_ff[9:2];
  assign wr_mapped = (aw_addr_ff[ADDR_W-1:10] == 2'h0) &&
                     (wr_idx == IDX_EDGE || wr_idx == IDX_REQ || wr_idx == IDX_EN ||
                      wr_idx == IDX_STACK_POINTER_REG || wr_idx == IDX_STAT || wr_idx == IDX_MASK);
  assign wr_en = do_write & w_lane_ff & (aw_addr_ff[ADDR_W-1:10] == 2'h0) & (wr_idx == IDX_EN);
  assign wr_req = do_write & w_lane_ff & (aw_addr_ff[ADDR_W-1:10] == 2'h0) & (wr_idx == IDX_REQ);
  assign wr_edge = do_write & w_lane_ff & (aw_addr_ff[ADDR_W-1:10] == 2'h0) & (wr_idx == IDX_EDGE);
  assign wr_stack_pointer_reg = do_write & w_lane_ff & (aw_addr_ff[ADDR_W-1:10] == 2'h0) & (wr_idx == IDX_STACK_POINTER_REG);
  assign wr_stat = do_write & w_lane_ff & (aw_addr_ff[ADDR_W-1:10] == 2'h0) & (wr_idx == IDX_STAT);
  assign wr_mask = do_write & w_lane_ff & (aw_addr_ff[ADDR_W-1:10] == 2'h0) & (wr_idx == IDX_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= '0;
      aw_full_ff <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_full_ff & ~(s_axi_awvalid & s_axi_awready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_full_ff <= 1'b1;
      end else if (do_write) begin
        aw_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      w_full_ff <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_full_ff & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
        w_full_ff <= 1'b1;
      end else if (do_write) begin
        w_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // bus read channel
  // ------------------------------------------------------------
  assign do_read = s_axi_arvalid & s_axi_arready;
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_mapped = (s_axi_araddr[ADDR_W-1:10] == 2'h0) &&
                     (rd_idx == IDX_EDGE || rd_idx == IDX_REQ || rd_idx == IDX_EN ||
                      rd_idx == IDX_STACK_POINTER_REG || rd_idx == IDX_STAT || rd_idx == IDX_MASK);

  always_comb begin
    rd_val = 8'h00;
    if (s_axi_araddr[ADDR_W-1:10] == 2'h0) begin
      if (rd_idx == IDX_EDGE) begin
        rd_val = edge_sel_ff;
      end else if (rd_idx == IDX_REQ) begin
        rd_val = int_req_ff;
      end else if (rd_idx == IDX_EN) begin
        rd_val = int_en_ff;
      end else if (rd_idx == IDX_STACK_POINTER_REG) begin
        rd_val = stack_pointer_reg_ff;
      end else if (rd_idx == IDX_STAT) begin
        rd_val = stat_ff;
      end else if (rd_idx == IDX_MASK) begin
        rd_val = mask_ff;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_sel_ff <= EDGE_RST;
    end else if (wr_edge) begin
      edge_sel_ff <= w_data_ff & EDGE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en_ff <= 8'h00;
    end else if (wr_en) begin
      int_en_ff <= w_data_ff & SRC_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= 8'h00;
    end else if (wr_mask) begin
      mask_ff <= w_data_ff & SRC_MASK;
    end
  end

  // ------------------------------------------------------------
  // request flags: software writes, hardware sets win
  // ------------------------------------------------------------
  always_comb begin
    nxt_req = wr_req ? (w_data_ff & SRC_MASK) : int_req_ff;
    nxt_req = nxt_req | hw_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_req_ff <= 8'h00;
    end else begin
      int_req_ff <= nxt_req;
    end
  end

  // ------------------------------------------------------------
  // event status, write one to clear
  // ------------------------------------------------------------
  always_comb begin
    nxt_stat = wr_stat ? (stat_ff & ~w_data_ff) : stat_ff;
    nxt_stat = nxt_stat | hw_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= 8'h00;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_stat & mask_ff & SRC_MASK);
    end
  end

  // ------------------------------------------------------------
  // global enable and stack level bits
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_pointer_reg_ff <= STACK_POINTER_REG_RST;
    end else begin
      if (wr_stack_pointer_reg) begin
        stack_pointer_reg_ff[1:0] <= w_data_ff[1:0];
        stack_pointer_reg_ff[BIT_GIE] <= w_data_ff[BIT_GIE];
      end
      if (return_from_interrupt) begin
        stack_pointer_reg_ff[BIT_GIE] <= 1'b1;
      end
      if (take) begin
        stack_pointer_reg_ff[BIT_GIE] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // vectoring
  // ------------------------------------------------------------
  // each source only counts with its own enable and the global enable
  assign pending = stack_pointer_reg_ff[BIT_GIE] & (|(int_en_ff & int_req_ff & SRC_MASK) |
                                       (wake_latch_ff & int_en_ff[BIT_EXT]));
  assign take = pending & core_accept & ~vector_load;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_load <= 1'b0;
      stack_push <= 1'b0;
      vector_pc <= VECTOR_ADDR;
    end else begin
      vector_load <= take;
      stack_push <= take;
      vector_pc <= VECTOR_ADDR;
    end
  end

  // ------------------------------------------------------------
  // power-down wake latch
  // ------------------------------------------------------------
  // the latched edge holds the core at the vector before its first fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_latch_ff <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      wake_up <= power_down_mode & ext_hit;
      if (power_down_mode & ext_hit) begin
        wake_latch_ff <= 1'b1;
      end else if (take | (core_accept & ~pending)) begin
        wake_latch_ff <= 1'b0;
      end
    end
  end

endmodule // tsic_top

// File: testbench/tb.sv
`timescale 1ns/1ns
module tb;
  import tsic_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic external_pin_interrupt = 1'h0, timer_a_overflow = 1'h0, timer_b_overflow = 1'h0, power_down_mode = 1'h0;
  logic push_save = 1'h0, pop_restore = 1'h0, slow = 1'h0, ret_req = 1'h0;
  logic core_accept, return_from_interrupt, vector_load, stack_push, wake_up, restore_load, irq;
  logic [7:0] accumulator_reg = '0, program_flag_reg = '0, acc_restore, program_flag_reg_restore, vcnt, a, f, g;
  logic [PC_W-1:0] vector_pc;
  int num_errors = 0, tests_run = 0, wcnt = 0;
  logic [33:0] exp_q[$];
  always #25 aclk = ~aclk;
  tsic_top dut (.*);
  tsic_core_model core (.aclk(aclk), .aresetn(aresetn), .slow(slow), .asleep(power_down_mode),
    .ret_req(ret_req), .vector_load(vector_load), .core_accept(core_accept),
    .return_from_interrupt(return_from_interrupt), .vcnt(vcnt));
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok);
    tests_run++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    hang(n);
    chk(s_axi_bresp === r);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    exp_q.push_back({r, 24'h0, d});
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    hang(n);
  endtask
  task automatic tmr(input logic ta, input logic tb_);
    timer_a_overflow <= ta;
    timer_b_overflow <= tb_;
    @(posedge aclk);
    timer_a_overflow <= 1'h0;
    timer_b_overflow <= 1'h0;
    tick(4);
  endtask
  // oldest expected read is matched against each accepted answer
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
      if (exp_q.size() == 0) chk(1'h0);
      else chk({s_axi_rresp, s_axi_rdata} === exp_q.pop_front());
    end
    if (wake_up === 1'h1) wcnt++;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h92101e5f));
    tick(20);
    aresetn <= 1'h1;
    tick(2);
    rd(IDX_EDGE, EDGE_RST);
    rd(IDX_REQ, 8'h00);
    rd(IDX_EN, 8'h00);
    rd(IDX_STACK_POINTER_REG, STACK_POINTER_REG_RST);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(8'h00, 8'h5a, RESP_SLVERR);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_EDGE, {3'h0, c[1:0], 3'h0});
      wr(IDX_REQ, 8'h00);
      external_pin_interrupt <= 1'h1;
      tick(4);
      rd(IDX_REQ, {7'h0, c[0]});
      wr(IDX_REQ, 8'h00);
      external_pin_interrupt <= 1'h0;
      tick(4);
      rd(IDX_REQ, {7'h0, c[1]});
    end
    wr(IDX_STACK_POINTER_REG, 8'h83);
    tmr(1'h1, 1'h1);
    rd(IDX_REQ, 8'h31);
    chk(vcnt === 8'h00);
    wr(IDX_REQ, 8'h00);
    slow <= 1'h1;
    wr(IDX_EN, 8'h10);
    rd(IDX_EN, 8'h10);
    s_axi_wstrb <= 4'he;
    wr(IDX_EN, 8'h31);
    s_axi_wstrb <= 4'hf;
    rd(IDX_EN, 8'h10);
    tmr(1'h1, 1'h0);
    tick(8);
    chk(vcnt === 8'h01);
    rd(IDX_STACK_POINTER_REG, 8'h03);
    rd(IDX_REQ, 8'h10);
    wr(IDX_REQ, 8'h00);
    ret_req <= 1'h1;
    @(posedge aclk);
    ret_req <= 1'h0;
    tick(3);
    rd(IDX_STACK_POINTER_REG, 8'h83);
    wr(IDX_STACK_POINTER_REG, 8'h03);
    tmr(1'h1, 1'h0);
    tick(8);
    chk(vcnt === 8'h01);
    wr(IDX_REQ, 8'h00);
    rd(IDX_STAT, 8'h31);
    wr(IDX_MASK, 8'h20);
    tick(2);
    chk(irq === 1'h1);
    wr(IDX_STAT, 8'h20);
    tick(2);
    chk(irq === 1'h0);
    rd(IDX_STAT, 8'h11);
    wr(IDX_EDGE, 8'h10);
    wr(IDX_EN, 8'h01);
    external_pin_interrupt <= 1'h1;
    tick(4);
    wr(IDX_REQ, 8'h00);
    wr(IDX_STACK_POINTER_REG, 8'h83);
    power_down_mode <= 1'h1;
    tick(2);
    external_pin_interrupt <= 1'h0;
    tick(4);
    chk(wcnt == 1);
    chk(vcnt === 8'h01);
    power_down_mode <= 1'h0;
    tick(8);
    chk(vcnt === 8'h02);
    repeat (4) begin
      a = $urandom;
      f = $urandom;
      g = $urandom;
      accumulator_reg <= a;
      program_flag_reg <= f;
      push_save <= 1'h1;
      @(posedge aclk);
      push_save <= 1'h0;
      pop_restore <= 1'h1;
      program_flag_reg <= g;
      @(posedge aclk);
      pop_restore <= 1'h0;
      #1;
      chk(restore_load === 1'h1 && acc_restore === a && program_flag_reg_restore === {g[7:6], f[5:0]});
    end
    tick(4);
    conclude();
  end
endmodule // tb

// File: testbench/tsic_asserts.sv
`timescale 1ns/1ns
module tsic_asserts
  import tsic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_down_mode,
  input wire logic core_accept,
  input wire logic push_save,
  input wire logic pop_restore,
  input wire logic [7:0] accumulator_reg,
  input wire logic [7:0] program_flag_reg,
  input wire logic vector_load,
  input wire logic [PC_W-1:0] vector_pc,
  input wire logic stack_push,
  input wire logic wake_up,
  input wire logic [7:0] acc_restore,
  input wire logic [7:0] program_flag_reg_restore,
  input wire logic restore_load
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // vectoring
  // ----------------------------------------
  a_vec_target: assert property (vector_load |-> stack_push && vector_pc == VECTOR_ADDR)
    else $error("vector without push or off address");
  a_vec_cause: assert property (vector_load |-> $past(core_accept))
    else $error("vector without core boundary");
  a_push_pairs: assert property ($rose(stack_push) |-> $rose(vector_load))
    else $error("push without vector");
  a_vec_gap: assert property (vector_load |=> !vector_load)
    else $error("vector longer than one cycle");
  a_wake_cause: assert property (wake_up |-> $past(power_down_mode))
    else $error("wake outside power down");
  // ----------------------------------------
  // shadow buffer
  // ----------------------------------------
  sequence s_save_pop;
    push_save ##1 pop_restore;
  endsequence
  a_restore_next: assert property (pop_restore |=> restore_load)
    else $error("restore not loaded");
  a_restore_data: assert property (s_save_pop |=> acc_restore == $past(accumulator_reg, 2) &&
    ((program_flag_reg_restore ^ $past(program_flag_reg, 2)) & 8'h3f) == 8'h00)
    else $error("restored data differs from saved");
  a_flags_kept: assert property (restore_load |->
    (program_flag_reg_restore & PROGRAM_FLAG_REG_KEEP) == ($past(program_flag_reg) & PROGRAM_FLAG_REG_KEEP))
    else $error("status flags overwritten");
endmodule // tsic_asserts

bind tsic_top tsic_asserts chk_i (.aclk(aclk), .aresetn(aresetn), .power_down_mode(power_down_mode),
  .core_accept(core_accept), .push_save(push_save), .pop_restore(pop_restore),
  .accumulator_reg(accumulator_reg), .program_flag_reg(program_flag_reg), .vector_load(vector_load),
  .vector_pc(vector_pc), .stack_push(stack_push), .wake_up(wake_up), .acc_restore(acc_restore),
  .program_flag_reg_restore(program_flag_reg_restore), .restore_load(restore_load));

// File: testbench/tsic_core_model.sv
`timescale 1ns/1ns
module tsic_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic asleep,
  input wire logic ret_req,
  input wire logic vector_load,
  output logic core_accept,
  output logic return_from_interrupt,
  output logic [7:0] vcnt
);
  logic [1:0] phase_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= 2'h0;
      vcnt <= 8'h00;
      return_from_interrupt <= 1'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      return_from_interrupt <= ret_req;
      if (vector_load) begin
        vcnt <= vcnt + 8'h01;
      end
    end
  end
  // no boundary while asleep; a slow core reaches one every fourth cycle
  assign core_accept = !asleep && (!slow || phase_ff == 2'h0);
endmodule // tsic_core_model
